// *** design/sgc_regs.sv ***
// Purpose: sound generator control registers and tone engine behind AXI4-Lite
// Assumes: synchronous active-low reset, single clock, full-word or byte-strobed writes
// Notes:   stored-sound handoff into the internal sound register marks the buffer empty unless a data write lands in the same cycle
// Functional notes
// - stop bit starts stop, reads busy-stopping
// - stop forcibly ends one-shot and melody
// - module enable gates all operation; code gates the tone engine and data/stop writes only, not irq or dma_req
// - writing data buffer starts sound output
// - low byte scale or frequency, resets ff
// - bits 13-8 duration or duty
// - bit 15 ties note in melody
// - bit 14 rest: true low, complement high
// - buzzer modes use low six frequency bits
// - data register needs full 16-bit writes
// - busy flag bit 8 while outputting
// - empty flag resets 1, data write clears
// - done flag cleared by one or data
// - irq enable bits 1 and 0
// - dma enable per channel bit
// - unimplemented channel bits have no effect
// - empty sets on transfer or stop
// - irq only when flag and enable
// - dma request when empty and enabled
// - mode codes 0,1,2; 3 reserved
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module sgc_regs #(
   parameter int DMA_CH = 16
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [4:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [4:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output sgc_pkg::sgc_pins_s         buzzer_pins,
   output logic                       irq,
   output logic [DMA_CH-1:0]          dma_req
);
   if (DMA_CH < 1 || DMA_CH > 16) begin : g_bad_dma_ch
      $error("DMA_CH must be 1..16");
   end

   typedef sgc_pkg::sgc_mode_e sgc_mode_e_t;
   typedef struct packed {
      logic                aw_got;
      logic [4:0]          aw_addr;
      logic                w_got;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                module_enable;
      logic                stop_output;
      sgc_mode_e_t         mode;
      sgc_pkg::sgc_note_s  buf_data;
      logic                buf_full;
      sgc_pkg::sgc_note_s  snd;
      logic                output_busy;
      logic                buffer_empty_flag;
      logic                output_done_flag;
      logic                buffer_empty_irq_en;
      logic                output_done_irq_en;
      logic [15:0]         empty_dma_channel_en;
      logic [15:0]         dur_cnt;
      logic [7:0]          tick_cnt;
      logic [7:0]          phase;
      logic                tone;
   } sgc_state_s;

   sgc_state_s st_r;
   sgc_state_s st_nxt;

   function automatic logic [31:0] sgc_rd(input sgc_state_s s, input logic [4:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         sgc_pkg::OFF_CTL: begin
            v[sgc_pkg::CTL_STOP_BIT] = s.stop_output;
            v[sgc_pkg::CTL_EN_BIT]   = s.module_enable;
         end
         sgc_pkg::OFF_DAT:   v[15:0] = s.buf_data;
         sgc_pkg::OFF_FLAGS: begin
            v[sgc_pkg::FLG_BUSY_BIT]  = s.output_busy;
            v[sgc_pkg::FLG_EMPTY_BIT] = s.buffer_empty_flag;
            v[sgc_pkg::FLG_DONE_BIT]  = s.output_done_flag;
         end
         sgc_pkg::OFF_IRQEN: begin
            v[1] = s.buffer_empty_irq_en;
            v[0] = s.output_done_irq_en;
         end
         sgc_pkg::OFF_DMAEN: v[15:0] = s.empty_dma_channel_en;
         sgc_pkg::OFF_SEL:   v[1:0]  = s.mode;
         default:            v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic sgc_mapped(input logic [4:0] a);
      return (a == sgc_pkg::OFF_CTL) || (a == sgc_pkg::OFF_DAT) || (a == sgc_pkg::OFF_FLAGS)
          || (a == sgc_pkg::OFF_IRQEN) || (a == sgc_pkg::OFF_DMAEN) || (a == sgc_pkg::OFF_SEL);
   endfunction

   logic        wr_fire;
   logic        dat_wr;
   logic        stop_wr;
   logic        full16;
   logic [15:0] period;
   logic [15:0] hi_cnt;
   logic [15:0] note_len;
   logic        note_end;
   logic        tick;
   logic        load;
   logic        a_is_dat;

   assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
   assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign a_is_dat      = (st_r.aw_addr == sgc_pkg::OFF_DAT);

   always_comb begin
      logic [4:0]  a;
      logic [31:0] d;
      a = 5'h00;
      d = 32'h0000_0000;
      st_nxt  = st_r;
      wr_fire = st_r.aw_got && st_r.w_got;
      a       = st_r.aw_addr;
      d       = st_r.w_data;
      full16  = (st_r.w_strb[1:0] == 2'h3);
      dat_wr  = wr_fire && (a == sgc_pkg::OFF_DAT) && full16;
      stop_wr = wr_fire && (a == sgc_pkg::OFF_CTL) && st_r.w_strb[1]
                && d[sgc_pkg::CTL_STOP_BIT] && st_r.module_enable;
      // buzzer modes use six frequency bits, melody all eight
      period   = (st_r.mode == sgc_pkg::SGC_MELODY)
                 ? {8'h00, st_r.snd.scale_or_frequency} + 16'h0001
                 : {10'h000, st_r.snd.scale_or_frequency[5:0]} + 16'h0001;
      hi_cnt   = {10'h000, st_r.snd.length_or_duty};
      note_len = 16'((32'(st_r.snd.length_or_duty) + 32'd1) * sgc_pkg::LEN_UNIT);
      tick     = (st_r.tick_cnt == 8'(sgc_pkg::TICK_DIV - 1));
      note_end = st_r.output_busy && tick && (st_r.dur_cnt == 16'h0000)
                 && (st_r.mode != sgc_pkg::SGC_NORMAL);
      load     = (!st_r.output_busy || note_end) && st_r.buf_full && !st_r.stop_output;

      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = {s_axi_awaddr[4:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
      if (s_axi_rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = sgc_rd(st_r, {s_axi_araddr[4:2], 2'h0});
         st_nxt.rresp  = sgc_mapped({s_axi_araddr[4:2], 2'h0}) ? sgc_pkg::RESP_OKAY
                                                               : sgc_pkg::RESP_SLVERR;
      end

      if (wr_fire) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = sgc_mapped(a) ? sgc_pkg::RESP_OKAY : sgc_pkg::RESP_SLVERR;
         unique case (a)
            sgc_pkg::OFF_CTL:
               if (st_r.w_strb[0]) st_nxt.module_enable = d[sgc_pkg::CTL_EN_BIT];
            sgc_pkg::OFF_IRQEN:
               if (st_r.w_strb[0]) begin
                  st_nxt.buffer_empty_irq_en = d[1];
                  st_nxt.output_done_irq_en  = d[0];
               end
            sgc_pkg::OFF_DMAEN: begin
               if (st_r.w_strb[0]) st_nxt.empty_dma_channel_en[7:0]  = d[7:0];
               if (st_r.w_strb[1]) st_nxt.empty_dma_channel_en[15:8] = d[15:8];
            end
            sgc_pkg::OFF_SEL:
               if (st_r.w_strb[0]) st_nxt.mode = sgc_mode_e_t'(d[1:0]);
            sgc_pkg::OFF_FLAGS:
               if (st_r.w_strb[0] && d[sgc_pkg::FLG_DONE_BIT])
                  st_nxt.output_done_flag = 1'b0;
            default: ;
         endcase
      end

      // tone engine, frozen while the module is disabled
      if (st_r.module_enable) begin
         st_nxt.tick_cnt = tick ? 8'h00 : st_r.tick_cnt + 8'h01;
         if (st_r.output_busy && tick) begin
            st_nxt.phase = (st_r.phase + 8'h01 >= period[7:0] || period[8])
                           ? 8'h00 : st_r.phase + 8'h01;
            if (st_r.dur_cnt != 16'h0000) st_nxt.dur_cnt = st_r.dur_cnt - 16'h0001;
         end
         // rest holds the true output low
         st_nxt.tone = st_r.output_busy && !(st_r.mode == sgc_pkg::SGC_MELODY
                       && st_r.snd.rest_select)
                       && ({8'h00, st_r.phase} <= hi_cnt);
         if (dat_wr) begin
            st_nxt.buf_data          = d[15:0];
            st_nxt.buf_full          = 1'b1;
            st_nxt.buffer_empty_flag = 1'b0;
            st_nxt.output_done_flag  = 1'b0;
         end
         if (load) begin
            st_nxt.snd               = st_r.buf_data;
            st_nxt.buf_full          = dat_wr;
            st_nxt.output_busy       = 1'b1;
            st_nxt.buffer_empty_flag = !dat_wr;
            st_nxt.dur_cnt           = note_len;
            st_nxt.tick_cnt          = 8'h00;
            // tied notes keep the running phase
            if (!(st_r.mode == sgc_pkg::SGC_MELODY && st_r.buf_data.tie_to_previous
                  && note_end)) st_nxt.phase = 8'h00;
         end else if (note_end) begin
            st_nxt.output_busy      = 1'b0;
            st_nxt.output_done_flag = 1'b1;
         end
         if (stop_wr) begin
            st_nxt.stop_output       = 1'b1;
            st_nxt.buf_full          = 1'b0;
            st_nxt.buffer_empty_flag = 1'b1;
         end
         if (st_r.stop_output && tick) begin
            // forced end in every mode
            st_nxt.stop_output      = 1'b0;
            st_nxt.output_busy      = 1'b0;
            st_nxt.tone             = 1'b0;
            st_nxt.output_done_flag = st_r.output_busy || st_r.output_done_flag;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r                   <= '0;
         st_r.buf_data          <= sgc_pkg::DAT_RESET;
         st_r.buffer_empty_flag <= 1'b1;
         st_r.empty_dma_channel_en <= sgc_pkg::DMAEN_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign buzzer_pins.buzzer_out_true       = st_r.tone;
   assign buzzer_pins.buzzer_out_complement = !st_r.tone;
   assign irq = (st_r.buffer_empty_flag && st_r.buffer_empty_irq_en)
             || (st_r.output_done_flag && st_r.output_done_irq_en);
   assign dma_req = {DMA_CH{st_r.buffer_empty_flag}}
                  & st_r.empty_dma_channel_en[DMA_CH-1:0];

   sequence s_stop_req;
      stop_wr;
   endsequence
   sequence s_stop_done;
      !st_r.stop_output && !st_r.output_busy;
   endsequence
   sequence s_load;
      load && st_r.module_enable;
   endsequence

   a_stop_sets_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      stop_wr |=> st_r.stop_output) else $error("stop bit not set");
   a_stop_ends_out: assert property (@(posedge aclk) disable iff (!aresetn)
      s_stop_req |-> ##[1:12] s_stop_done) else $error("stop did not end output");
   a_stop_finish: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.stop_output && tick && st_r.module_enable |=> s_stop_done)
      else $error("stop did not complete on tick");
   a_stop_empty: assert property (@(posedge aclk) disable iff (!aresetn)
      s_stop_req |=> st_r.buffer_empty_flag) else $error("stop did not mark buffer empty");
   a_load_empty: assert property (@(posedge aclk) disable iff (!aresetn)
      s_load |=> st_r.output_busy && (st_r.buffer_empty_flag == !$past(dat_wr)))
      else $error("buffer handoff flag wrong");
   a_disabled_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.module_enable && !wr_fire |=> $stable(st_r.output_busy))
      else $error("engine moved while disabled");
   a_disabled_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.module_enable |=> $stable(st_r.tone) && $stable(st_r.dur_cnt))
      else $error("tone moved while disabled");
   a_write_starts: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.module_enable && dat_wr && !st_r.output_busy && !st_r.stop_output
      |=> ##[1:2] st_r.output_busy)
      else $error("data write did not start output");
   a_rest_level: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.output_busy && st_r.mode == sgc_pkg::SGC_MELODY && st_r.snd.rest_select
      && $past(st_r.snd.rest_select) && $past(st_r.output_busy)
      && $past(st_r.mode) == sgc_pkg::SGC_MELODY
      |-> !buzzer_pins.buzzer_out_true && buzzer_pins.buzzer_out_complement)
      else $error("rest level wrong");
   a_byte_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && a_is_dat && !full16 |=> $stable(st_r.buf_data))
      else $error("byte write changed data");
   a_empty_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.module_enable && dat_wr && st_r.output_busy && !note_end && !stop_wr
      |=> !st_r.buffer_empty_flag) else $error("empty flag not cleared");
   a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.module_enable && dat_wr && !note_end && !st_r.stop_output
      |=> !st_r.output_done_flag) else $error("done flag not cleared");
   a_note_done: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.module_enable && note_end && !st_r.buf_full
      |=> !st_r.output_busy && st_r.output_done_flag) else $error("note end not idle");
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> (st_r.buffer_empty_flag && st_r.buffer_empty_irq_en)
           || (st_r.output_done_flag && st_r.output_done_irq_en))
      else $error("irq without enabled flag");
   a_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_req[0] == (st_r.buffer_empty_flag && st_r.empty_dma_channel_en[0]))
      else $error("dma request mismatch");
   a_mode_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && st_r.aw_addr == sgc_pkg::OFF_SEL && st_r.w_strb[0]
      |=> st_r.mode == $past(st_r.w_data[1:0])) else $error("mode select not taken");
   a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && !sgc_mapped({s_axi_araddr[4:2], 2'h0})
      |=> s_axi_rresp == sgc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
endmodule // sgc_regs

// *** design/sgc_pkg.sv ***
// Purpose: shared constants and carriers for the sound generator control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets chosen for this block
package sgc_pkg;
   localparam logic [4:0]  OFF_CTL    = 5'h00;
   localparam logic [4:0]  OFF_DAT    = 5'h04;
   localparam logic [4:0]  OFF_FLAGS  = 5'h08;
   localparam logic [4:0]  OFF_IRQEN  = 5'h0c;
   localparam logic [4:0]  OFF_DMAEN  = 5'h10;
   localparam logic [4:0]  OFF_SEL    = 5'h14;
   localparam int          CTL_STOP_BIT   = 8;
   localparam int          CTL_EN_BIT     = 0;
   localparam int          FLG_BUSY_BIT   = 8;
   localparam int          FLG_EMPTY_BIT  = 1;
   localparam int          FLG_DONE_BIT   = 0;
   localparam logic [15:0] DAT_RESET      = 16'h00ff;
   localparam logic [15:0] DMAEN_RESET    = 16'h0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // output tick in operating clock cycles, duration base in output ticks
   localparam int          TICK_DIV       = 4;
   localparam int          LEN_UNIT       = 16;

   typedef enum logic [1:0] {
      SGC_NORMAL  = 2'h0,
      SGC_ONESHOT = 2'h1,
      SGC_MELODY  = 2'h2,
      SGC_RSVD    = 2'h3
   } sgc_mode_e;

   typedef struct packed {
      logic       tie_to_previous;
      logic       rest_select;
      logic [5:0] length_or_duty;
      logic [7:0] scale_or_frequency;
   } sgc_note_s;

   typedef struct packed {
      logic       buzzer_out_true;
      logic       buzzer_out_complement;
   } sgc_pins_s;
endpackage

// *** sim/sgc_buzzer_model.sv ***
// Purpose: buzzer model on the complementary output pins
// Assumes: pins sampled on aclk, reset synchronous active low
// Notes:   counts edges of the true pin, flags a broken pair
`timescale 1ns/10ps
module sgc_buzzer_model (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire sgc_pkg::sgc_pins_s pins,
   output logic [15:0]             edge_cnt,
   output logic                    bad_pair
);
   logic last_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_cnt <= 16'h0000;
         bad_pair <= 1'b0;
         last_r   <= 1'b0;
      end else begin
         last_r <= pins.buzzer_out_true;
         if (pins.buzzer_out_true !== last_r) edge_cnt <= edge_cnt + 16'h0001;
         // piezo needs true and complement opposite at all times
         if (pins.buzzer_out_complement !== ~pins.buzzer_out_true) bad_pair <= 1'b1;
      end
   end
endmodule // sgc_buzzer_model

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the sound generator control block
// Assumes: AXI4-Lite master tasks, buzzer model on the pins
// Notes:   four dma channels so unimplemented enable bits are seen
`timescale 1ns/10ps
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf, dma_req;
   logic awready, wready, bvalid, arready, rvalid, irq, bad_pair;
   logic [1:0] bresp, rresp;
   logic [15:0] edge_cnt, e0;
   sgc_pkg::sgc_pins_s pins;
   int miscompares = 0, num_checks = 0;
   always #4 aclk = ~aclk;
   sgc_regs #(.DMA_CH(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .buzzer_pins(pins),
      .irq(irq), .dma_req(dma_req));
   sgc_buzzer_model u_buz (.aclk(aclk), .aresetn(aresetn), .pins(pins),
      .edge_cnt(edge_cnt), .bad_pair(bad_pair));
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                     input logic [1:0] er = sgc_pkg::RESP_OKAY);
      bit ad, wd, bd;
      int n;
      ad = 0; wd = 0; bd = 0; n = 0;
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!bd && n < 200) begin
         @(posedge aclk);
         n++;
         if (bvalid && ad && wd) begin bd = 1; chk(bresp, er); bready <= 1'b0; end
         if (awready && awvalid && !ad) begin ad = 1; awvalid <= 1'b0; end
         if (wready && wvalid && !wd) begin wd = 1; wvalid <= 1'b0; end
      end
      @(posedge aclk);
      if (!bd) chk(32'h0, 32'h1);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d,
                     input logic [1:0] er = sgc_pkg::RESP_OKAY);
      bit ad, dd;
      int n;
      ad = 0; dd = 0; n = 0; d = 32'hx;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!dd && n < 200) begin
         @(posedge aclk);
         n++;
         if (rvalid && ad) begin dd = 1; d = rdata; chk(rresp, er); rready <= 1'b0; end
         if (arready && arvalid && !ad) begin ad = 1; arvalid <= 1'b0; end
      end
      @(posedge aclk);
      if (!dd) chk(32'h0, 32'h1);
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] d;
      int n;
      n = 0;
      do begin rd(a, d); n++; end while ((d & m) !== exp && n < 100);
      chk(d & m, exp);
   endtask
   task automatic t_reset;
      rchk(sgc_pkg::OFF_CTL, 32'h0);
      rchk(sgc_pkg::OFF_DAT, 32'h00ff);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0002);
      rchk(sgc_pkg::OFF_IRQEN, 32'h0);
      rchk(sgc_pkg::OFF_DMAEN, 32'h0);
      chk({irq, dma_req, pins}, {25'h0, 1'b0, 4'h0, 2'b01});
   endtask
   task automatic t_regs;
      logic [31:0] d;
      wr(sgc_pkg::OFF_IRQEN, 32'hffff);
      rchk(sgc_pkg::OFF_IRQEN, 32'h0003);
      wr(sgc_pkg::OFF_IRQEN, 32'h0);
      wr(sgc_pkg::OFF_DMAEN, 32'hffff);
      rchk(sgc_pkg::OFF_DMAEN, 32'hffff);
      wr(sgc_pkg::OFF_DMAEN, 32'h0);
      wr(5'h18, 32'h1, 4'hf, sgc_pkg::RESP_SLVERR);
      rd(5'h18, d, sgc_pkg::RESP_SLVERR);
      chk(d, 32'h0);
      wr(sgc_pkg::OFF_DAT, 32'h0005);
      rchk(sgc_pkg::OFF_DAT, 32'h00ff);
      wr(sgc_pkg::OFF_CTL, 32'h1);
      wr(sgc_pkg::OFF_DAT, 32'h0805, 4'h1);
      rchk(sgc_pkg::OFF_DAT, 32'h00ff);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0002);
   endtask
   task automatic t_normal;
      wr(sgc_pkg::OFF_SEL, 32'h0);
      e0 = edge_cnt;
      wr(sgc_pkg::OFF_DAT, 32'h0205);
      repeat (40) @(posedge aclk);
      rchk(sgc_pkg::OFF_DAT, 32'h0205);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0102);
      chk(edge_cnt - e0 > 16'h0002, 32'h1);
      wr(sgc_pkg::OFF_DAT, 32'h0805);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0100);
      wr(sgc_pkg::OFF_CTL, 32'h0101);
      poll(sgc_pkg::OFF_CTL, 32'h0100, 32'h0);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0003);
   endtask
   task automatic t_irq_dma;
      wr(sgc_pkg::OFF_FLAGS, 32'h0);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0003);
      wr(sgc_pkg::OFF_FLAGS, 32'h1);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0002);
      wr(sgc_pkg::OFF_IRQEN, 32'h1);
      @(posedge aclk);
      chk(irq, 1'b0);
      wr(sgc_pkg::OFF_IRQEN, 32'h2);
      @(posedge aclk);
      chk(irq, 1'b1);
      wr(sgc_pkg::OFF_IRQEN, 32'h0);
      wr(sgc_pkg::OFF_DMAEN, 32'h8005);
      @(posedge aclk);
      chk({irq, dma_req}, 5'h05);
      wr(sgc_pkg::OFF_DMAEN, 32'h0);
   endtask
   task automatic t_melody;
      wr(sgc_pkg::OFF_SEL, 32'h2);
      e0 = edge_cnt;
      wr(sgc_pkg::OFF_DAT, 32'hc000);
      repeat (20) @(posedge aclk);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0102);
      poll(sgc_pkg::OFF_FLAGS, 32'h0100, 32'h0);
      chk({edge_cnt, pins}, {e0, 2'b01});
      rchk(sgc_pkg::OFF_DAT, 32'hc000);
   endtask
   task automatic t_oneshot;
      wr(sgc_pkg::OFF_SEL, 32'h1);
      wr(sgc_pkg::OFF_DAT, 32'h3f05);
      repeat (20) @(posedge aclk);
      rchk(sgc_pkg::OFF_FLAGS, 32'h0102);
      wr(sgc_pkg::OFF_CTL, 32'h0101);
      poll(sgc_pkg::OFF_FLAGS, 32'h0100, 32'h0);
      chk({bad_pair, pins}, 3'b001);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_normal();
      t_irq_dma();
      t_melody();
      t_oneshot();
      test_done();
   end
   initial begin
      repeat (30000) @(posedge aclk);
      miscompares++;
      test_done();
   end
endmodule // tb_top
